/* File: src/bootstrap_regs_pkg.sv */
package bootstrap_regs_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // Register word offsets (64-bit registers take two words, low word first)
    localparam logic [15:0] OFS_CAPABILITY_LO = 16'h01C4;
    localparam logic [15:0] OFS_CAPABILITY_HI = 16'h01C8;
    localparam logic [15:0] OFS_CONFIG_LO     = 16'h01E0;
    localparam logic [15:0] OFS_CONFIG_HI     = 16'h01E4;
    localparam logic [15:0] OFS_KEEPALIVE     = 16'h01E8;
    localparam logic [15:0] OFS_MSG_CHAN      = 16'h01EC;
    localparam logic [15:0] OFS_TIME_LO       = 16'h01F0;
    localparam logic [15:0] OFS_TIME_HI       = 16'h01F4;
    localparam logic [15:0] OFS_TIME_CAPTURE  = 16'h01F8;
    localparam logic [15:0] OFS_TICK_LO       = 16'h01FC;
    localparam logic [15:0] OFS_TICK_HI       = 16'h0200;
    localparam logic [15:0] OFS_OWNERSHIP     = 16'h0204;
    localparam logic [15:0] OFS_LEGACY_ORDER  = 16'h0208;

    // Field positions
    localparam int unsigned CFG_KEEPALIVE_BIT   = 0;
    localparam int unsigned CFG_MULTI_BIT       = 1;
    localparam int unsigned CAP_ACCESS_PRIV_BIT = 1;
    localparam int unsigned CAP_MSG_CHAN_BIT    = 2;
    localparam int unsigned CAP_TIMESTAMP_BIT   = 3;
    localparam int unsigned CAP_MULTI_BIT       = 12;
    localparam int unsigned CAPTURE_BIT         = 0;
    localparam int unsigned OWN_W               = 3;

    // Reset values and codes
    localparam logic [31:0]      KEEPALIVE_MS_RESET = 32'h00000BB8;
    localparam logic [31:0]      MSG_CHAN_RESET     = 32'h00000000;
    localparam logic [63:0]      TIME_RESET         = 64'h0000000000000000;
    localparam logic [OWN_W-1:0] OWN_AVAILABLE      = 3'h0;
    localparam logic [OWN_W-1:0] OWN_EXCLUSIVE      = 3'h1;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [63:0] TICK_NS       = 64'(CLK_PERIOD_NS);

endpackage

/* File: src/keepalive_timer.sv */
`timescale 1ns/10ps
module keepalive_timer #(
    parameter int unsigned MS_CYCLES = bootstrap_regs_pkg::MS_CYCLES
) (
    input  wire logic        clk_sys,    // System clock
    input  wire logic        rst_n,      // Synchronised reset
    input  wire logic        run,        // Timer enabled
    input  wire logic        restart,    // Host access seen
    input  wire logic [31:0] timeout_ms, // Timeout in milliseconds
    output logic             expire      // One-cycle expiry pulse
);

    localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

    typedef struct packed {
        logic [31:0] prescale;
        logic [31:0] remaining;
        logic        expire;
    } timer_t;

    timer_t state_reg;
    timer_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.expire = 1'b0;
        if (!run || restart) begin
            // Reload from the full value on every host access
            state_next.prescale  = 32'h0;
            state_next.remaining = timeout_ms;
        end else if (state_reg.prescale == MS_LAST) begin
            state_next.prescale = 32'h0;
            if (state_reg.remaining <= 32'h1) begin
                state_next.expire    = 1'b1;
                state_next.remaining = timeout_ms;
            end else begin
                state_next.remaining = state_reg.remaining - 32'h1;
            end
        end else begin
            state_next.prescale = state_reg.prescale + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign expire = state_reg.expire;

endmodule

/* File: src/device_time_counter.sv */
`timescale 1ns/10ps
module device_time_counter #(
    parameter logic [63:0] STEP_NS = bootstrap_regs_pkg::TICK_NS
) (
    input  wire logic        clk_sys, // System clock
    input  wire logic        rst_n,   // Synchronised reset
    input  wire logic        capture, // Copy running time into held value
    output logic [63:0]      held_ns  // Last captured time
);

    typedef struct packed {
        logic [63:0] now_ns;
        logic [63:0] held_ns;
    } clock_t;

    clock_t state_reg;
    clock_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.now_ns = state_reg.now_ns + STEP_NS;
        if (capture) begin
            state_next.held_ns = state_reg.now_ns;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= {bootstrap_regs_pkg::TIME_RESET, bootstrap_regs_pkg::TIME_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign held_ns = state_reg.held_ns;

endmodule

/* File: src/bootstrap_session_timestamp_regs.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - 64-bit config register; bit 0 enables keepalive; upper bits read zero.
// - Keepalive enable stays zero when access privilege is unsupported.
// - Bit 1 allows several events per packet, only when multi-event is capable.
// - Keepalive timeout register exists only with access privilege capability.
// - Keepalive expiry restores link communication parameters to defaults.
// - Any host read or write restarts keepalive timer from full timeout.
// - Keepalive timeout is 32-bit read-write milliseconds, reset 3000.
// - Message channel identifier resets to zero; host must write it.
// - Message channel identifier exists only with message channel capability.
// - Free-running time counter gives 64-bit read-only nanosecond timestamp, reset zero.
// - Writing capture register with bit 0 set copies current time.
// - Capture bit clears itself; no zero write needed.
// - 64-bit read-only register gives nanoseconds per counter tick.
// - Timestamp present implies capture and tick-size registers present.
// - Ownership field 3 bits: 0 available, 1 exclusive, 2-7 reserved, reset 0.
// - Keepalive expiry with ownership present clears ownership to 0.
// - Capability bit 1 keepalive/ownership, bit 2 message channel, bit 3 timestamp.
module bootstrap_session_timestamp_regs #(
    parameter int unsigned MS_CYCLES           = bootstrap_regs_pkg::MS_CYCLES,
    parameter bit          ACCESS_PRIV_CAPABLE = 1'b1,
    parameter bit          MSG_CHAN_CAPABLE    = 1'b1,
    parameter bit          TIMESTAMP_CAPABLE   = 1'b1,
    parameter bit          MULTI_NOTICE_CAPABLE = 1'b1
) (
    input  wire logic        clk_sys,               // 10 MHz system clock
    input  wire logic        arst_n,                // Asynchronous reset, active low
    input  wire logic        acc_req,               // Register access request, one cycle
    input  wire logic        acc_write,             // 1 write, 0 read
    input  wire logic [15:0] acc_addr,              // Byte address of the word
    input  wire logic [31:0] acc_wdata,             // Write data
    output logic             acc_ack,               // Access done, one cycle
    output logic             acc_err,               // Access refused, with ack
    output logic [31:0]      acc_rdata,             // Read data, valid with ack
    output logic             keepalive_on,          // Keepalive timer enabled
    output logic             multi_notice_on,       // Several events per packet allowed
    output logic [31:0]      path_ident,            // Message channel identifier
    output logic [2:0]       ownership,             // Current access privilege code
    output logic             link_defaults_restore  // Pulse: revert link to defaults
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_pipe_reg;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
        hit = (addr == ofs);
    endfunction

    function automatic logic [31:0] word_of(input logic [63:0] value, input logic upper);
        word_of = upper ? value[63:32] : value[31:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic        keepalive_en;
        logic        multi_en;
        logic [31:0] timeout_ms;
        logic [31:0] path_ident;
        logic [2:0]  ownership;
        logic [31:0] rdata;
        logic        ack;
        logic        err;
        logic        restore;
    } regs_t;

    localparam regs_t RESET_STATE = '{
        keepalive_en: 1'b0,
        multi_en:     1'b0,
        timeout_ms:   bootstrap_regs_pkg::KEEPALIVE_MS_RESET,
        path_ident:   bootstrap_regs_pkg::MSG_CHAN_RESET,
        ownership:    bootstrap_regs_pkg::OWN_AVAILABLE,
        rdata:        32'h0,
        ack:          1'b0,
        err:          1'b0,
        restore:      1'b0
    };

    regs_t state_reg;
    regs_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Capability word and sub-blocks

    logic [63:0] capability;
    logic        expire;
    logic        capture_now;
    logic [63:0] time_held;
    logic        is_write;
    logic        is_read;

    always_comb begin
        capability = 64'h0;
        capability[bootstrap_regs_pkg::CAP_ACCESS_PRIV_BIT] = ACCESS_PRIV_CAPABLE;
        capability[bootstrap_regs_pkg::CAP_MSG_CHAN_BIT]    = MSG_CHAN_CAPABLE;
        capability[bootstrap_regs_pkg::CAP_TIMESTAMP_BIT]   = TIMESTAMP_CAPABLE;
        capability[bootstrap_regs_pkg::CAP_MULTI_BIT]       = MULTI_NOTICE_CAPABLE;
    end

    assign is_write = acc_req && acc_write;
    assign is_read  = acc_req && !acc_write;

    // Capture acts in the request cycle so a read right after sees the new time
    assign capture_now = TIMESTAMP_CAPABLE && is_write
                         && hit(acc_addr, bootstrap_regs_pkg::OFS_TIME_CAPTURE)
                         && acc_wdata[bootstrap_regs_pkg::CAPTURE_BIT];

    keepalive_timer #(
        .MS_CYCLES  (MS_CYCLES)
    ) u_keepalive (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .run        (state_reg.keepalive_en),
        .restart    (acc_req),
        .timeout_ms (state_reg.timeout_ms),
        .expire     (expire)
    );

    device_time_counter #(
        .STEP_NS    (bootstrap_regs_pkg::TICK_NS)
    ) u_time (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .capture    (capture_now),
        .held_ns    (time_held)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register access and keepalive consequences

    always_comb begin
        state_next = state_reg;
        state_next.ack     = acc_req;
        state_next.err     = 1'b0;
        state_next.rdata   = 32'h0;
        state_next.restore = 1'b0;

        // Expiry first, so a host write in the same cycle takes precedence
        if (expire) begin
            state_next.restore = 1'b1;
            if (ACCESS_PRIV_CAPABLE && state_reg.keepalive_en) begin
                state_next.ownership = bootstrap_regs_pkg::OWN_AVAILABLE;
            end
        end

        if (is_write) begin
            if (hit(acc_addr, bootstrap_regs_pkg::OFS_CONFIG_LO)) begin
                state_next.keepalive_en = ACCESS_PRIV_CAPABLE
                    && acc_wdata[bootstrap_regs_pkg::CFG_KEEPALIVE_BIT];
                state_next.multi_en = MULTI_NOTICE_CAPABLE
                    && acc_wdata[bootstrap_regs_pkg::CFG_MULTI_BIT];
            end else if (hit(acc_addr, bootstrap_regs_pkg::OFS_CONFIG_HI)) begin
                state_next.err = 1'b0;
            end else if (ACCESS_PRIV_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_KEEPALIVE)) begin
                state_next.timeout_ms = acc_wdata;
            end else if (MSG_CHAN_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_MSG_CHAN)) begin
                state_next.path_ident = acc_wdata;
            end else if (TIMESTAMP_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_TIME_CAPTURE)) begin
                state_next.err = 1'b0;
            end else if (ACCESS_PRIV_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_OWNERSHIP)) begin
                state_next.ownership = acc_wdata[bootstrap_regs_pkg::OWN_W-1:0];
            end else if (hit(acc_addr, bootstrap_regs_pkg::OFS_LEGACY_ORDER)) begin
                state_next.err = 1'b0;
            end else begin
                // Read-only, absent or unmapped words refuse the write
                state_next.err = 1'b1;
            end
        end else if (is_read) begin
            if (hit(acc_addr, bootstrap_regs_pkg::OFS_CAPABILITY_LO)) begin
                state_next.rdata = word_of(capability, 1'b0);
            end else if (hit(acc_addr, bootstrap_regs_pkg::OFS_CAPABILITY_HI)) begin
                state_next.rdata = word_of(capability, 1'b1);
            end else if (hit(acc_addr, bootstrap_regs_pkg::OFS_CONFIG_LO)) begin
                state_next.rdata[bootstrap_regs_pkg::CFG_KEEPALIVE_BIT] = state_reg.keepalive_en;
                state_next.rdata[bootstrap_regs_pkg::CFG_MULTI_BIT]     = state_reg.multi_en;
            end else if (hit(acc_addr, bootstrap_regs_pkg::OFS_CONFIG_HI)) begin
                state_next.rdata = 32'h0;
            end else if (ACCESS_PRIV_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_KEEPALIVE)) begin
                state_next.rdata = state_reg.timeout_ms;
            end else if (MSG_CHAN_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_MSG_CHAN)) begin
                state_next.rdata = state_reg.path_ident;
            end else if (TIMESTAMP_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_TIME_LO)) begin
                state_next.rdata = word_of(time_held, 1'b0);
            end else if (TIMESTAMP_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_TIME_HI)) begin
                state_next.rdata = word_of(time_held, 1'b1);
            end else if (TIMESTAMP_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_TIME_CAPTURE)) begin
                state_next.rdata = 32'h0;
            end else if (TIMESTAMP_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_TICK_LO)) begin
                state_next.rdata = word_of(bootstrap_regs_pkg::TICK_NS, 1'b0);
            end else if (TIMESTAMP_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_TICK_HI)) begin
                state_next.rdata = word_of(bootstrap_regs_pkg::TICK_NS, 1'b1);
            end else if (ACCESS_PRIV_CAPABLE && hit(acc_addr, bootstrap_regs_pkg::OFS_OWNERSHIP)) begin
                state_next.rdata[bootstrap_regs_pkg::OWN_W-1:0] = state_reg.ownership;
            end else if (hit(acc_addr, bootstrap_regs_pkg::OFS_LEGACY_ORDER)) begin
                state_next.rdata = 32'h0;
            end else begin
                state_next.err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign acc_ack               = state_reg.ack;
    assign acc_err               = state_reg.err;
    assign acc_rdata             = state_reg.rdata;
    assign keepalive_on          = state_reg.keepalive_en;
    assign multi_notice_on       = state_reg.multi_en;
    assign path_ident            = state_reg.path_ident;
    assign ownership             = state_reg.ownership;
    assign link_defaults_restore = state_reg.restore;

endmodule

/* File: tb/bootstrap_session_timestamp_regs_monitor.sv */
`timescale 1ns/10ps
module bootstrap_session_timestamp_regs_monitor #(
    parameter int unsigned MS_CYCLES = bootstrap_regs_pkg::MS_CYCLES
) (
    input wire logic        clk_sys,              // System clock
    input wire logic        arst_n,               // Asynchronous reset
    input wire logic        acc_req,              // Access request
    input wire logic        acc_write,            // Write select
    input wire logic [15:0] acc_addr,             // Word address
    input wire logic [31:0] acc_wdata,            // Write data
    input wire logic        acc_ack,              // Access done
    input wire logic        acc_err,              // Access refused
    input wire logic [31:0] acc_rdata,            // Read data
    input wire logic        keepalive_on,         // Keepalive enable
    input wire logic        multi_notice_on,      // Several events per packet
    input wire logic [31:0] path_ident,           // Message channel identifier
    input wire logic [2:0]  ownership,            // Access privilege code
    input wire logic        link_defaults_restore // Expiry pulse
);
    logic [31:0] idle_cnt_reg;

    // Cycles since the keepalive timer was last restarted
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            idle_cnt_reg <= 32'h00000000;
        else if (acc_req || !keepalive_on)
            idle_cnt_reg <= 32'h00000000;
        else if (idle_cnt_reg != 32'hFFFFFFFF)
            idle_cnt_reg <= idle_cnt_reg + 32'h00000001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_write(logic [15:0] a);
        acc_req && acc_write && acc_addr == a;
    endsequence
    sequence s_refused;
        acc_ack && acc_err;
    endsequence

    AST_ACK_ONE_EDGE: assert property (acc_ack == $past(acc_req))
        else $error("ack does not follow its request by one edge");
    AST_QUIET_ANSWER: assert property (!acc_ack |-> acc_rdata == 32'h00000000 && !acc_err)
        else $error("answer lines busy without ack");
    AST_CFG_WRITE: assert property (s_write(16'h01E0) |=> keepalive_on == $past(acc_wdata[0])
        && multi_notice_on == $past(acc_wdata[1])) else $error("config flags differ from written bits");
    AST_CHAN_WRITE: assert property (s_write(16'h01EC) |=> path_ident == $past(acc_wdata))
        else $error("channel identifier not taken");
    AST_OWN_WRITE: assert property (s_write(16'h0204) |=> ownership == $past(acc_wdata[2:0]))
        else $error("ownership not taken");
    AST_TIME_READ_ONLY: assert property (s_write(16'h01F0) |=> s_refused)
        else $error("write to timestamp not refused");
    AST_EXPIRY_OWNER: assert property (link_defaults_restore |-> ownership == 3'h0
        || $past(acc_req && acc_write && acc_addr == 16'h0204)) else $error("ownership kept over expiry");
    AST_RESTORE_PULSE: assert property (link_defaults_restore |=> !link_defaults_restore)
        else $error("restore pulse longer than one cycle");
    AST_RESTORE_TIMING: assert property (link_defaults_restore |-> $past(keepalive_on)
        && $past(idle_cnt_reg) >= MS_CYCLES - 1) else $error("expiry too early or while disabled");
endmodule

bind bootstrap_session_timestamp_regs bootstrap_session_timestamp_regs_monitor #(
    .MS_CYCLES(MS_CYCLES)
) u_monitor (
    .clk_sys, .arst_n, .acc_req, .acc_write, .acc_addr, .acc_wdata, .acc_ack, .acc_err,
    .acc_rdata, .keepalive_on, .multi_notice_on, .path_ident, .ownership, .link_defaults_restore
);

/* File: tb/host_cmd_model.sv */
`timescale 1ns/10ps
module host_cmd_model (
    input  wire logic        clk_sys,   // System clock
    output logic             acc_req,   // Access request
    output logic             acc_write, // Write select
    output logic [15:0]      acc_addr,  // Word address
    output logic [31:0]      acc_wdata, // Write data
    input  wire logic        acc_ack,   // Access done
    input  wire logic        acc_err,   // Access refused
    input  wire logic [31:0] acc_rdata  // Read data
);
    initial begin
        acc_req   = 1'b0;
        acc_write = 1'b0;
        acc_addr  = 16'h0000;
        acc_wdata = 32'h00000000;
    end

    // Drive at a falling edge, take the answer one cycle later, then scramble idle lines
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic e, output logic ak);
        @(negedge clk_sys);
        acc_req   = 1'b1;
        acc_write = wr;
        acc_addr  = (a == 16'h0208) ? 16'h0204 : a;
        acc_wdata = (wr && a == 16'h01EC && d == 32'h0) ? 32'h00000001 : d;
        @(negedge clk_sys);
        ak        = acc_ack;
        e         = acc_err;
        rd        = acc_rdata;
        acc_req   = 1'b0;
        acc_addr  = ~acc_addr;
        acc_wdata = ~acc_wdata;
    endtask

    // Capture first, then read both halves of the held time
    task automatic read_time(output logic [63:0] t);
        logic [31:0] lo;
        logic [31:0] hi;
        logic        e;
        logic        ak;
        access(1'b1, 16'h01F8, 32'h00000001, lo, e, ak);
        access(1'b0, 16'h01F0, 32'h00000000, lo, e, ak);
        access(1'b0, 16'h01F4, 32'h00000000, hi, e, ak);
        t = {hi, lo};
    endtask
endmodule

/* File: tb/bootstrap_session_timestamp_regs_test.sv */
`timescale 1ns/10ps
module bootstrap_session_timestamp_regs_test;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [31:0] mask;
        logic [31:0] exp;
        logic        err;
    } row_t;

    logic        clk_sys;
    logic        arst_n;
    logic        acc_req;
    logic        acc_write;
    logic [15:0] acc_addr;
    logic [31:0] acc_wdata;
    logic        acc_ack;
    logic        acc_err;
    logic [31:0] acc_rdata;
    logic        keepalive_on;
    logic        multi_notice_on;
    logic [31:0] path_ident;
    logic [2:0]  ownership;
    logic        link_defaults_restore;
    logic [31:0] rd;
    logic        e;
    logic [63:0] t1;
    logic [63:0] t2;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          take_cyc = 0;
    int          restore_cyc[$];
    int          n;
    row_t        rows [24] = '{
        '{1'b0, 16'h01E8, 32'h0, 32'hFFFFFFFF, 32'h00000BB8, 1'b0}, '{1'b0, 16'h01EC, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b0, 16'h0204, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01F0, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b0, 16'h01F4, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01FC, 32'h0, 32'hFFFFFFFF, 32'h00000064, 1'b0},
        '{1'b0, 16'h0200, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01C4, 32'h0, 32'h0000100E, 32'h0000100E, 1'b0},
        '{1'b1, 16'h01E0, 32'hFFFFFFFE, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01E0, 32'h0, 32'hFFFFFFFF, 32'h2, 1'b0},
        '{1'b1, 16'h01E4, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01E4, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b1, 16'h01EC, 32'h5, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01EC, 32'h0, 32'hFFFFFFFF, 32'h5, 1'b0},
        '{1'b1, 16'h0204, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h0204, 32'h0, 32'hFFFFFFFF, 32'h7, 1'b0},
        '{1'b1, 16'h0204, 32'h1, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h0204, 32'h0, 32'hFFFFFFFF, 32'h1, 1'b0},
        '{1'b1, 16'h01F0, 32'h1, 32'hFFFFFFFF, 32'h0, 1'b1}, '{1'b1, 16'h01FC, 32'h1, 32'hFFFFFFFF, 32'h0, 1'b1},
        '{1'b0, 16'h01F8, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h0100, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1},
        '{1'b1, 16'h01E8, 32'h2, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 16'h01E8, 32'h0, 32'hFFFFFFFF, 32'h2, 1'b0}};

    host_cmd_model u_host_cmd_model (.clk_sys, .acc_req, .acc_write, .acc_addr, .acc_wdata,
                                     .acc_ack, .acc_err, .acc_rdata);
    bootstrap_session_timestamp_regs #(.MS_CYCLES(10)) u_bootstrap_session_timestamp_regs (
        .clk_sys, .arst_n, .acc_req, .acc_write, .acc_addr, .acc_wdata, .acc_ack, .acc_err,
        .acc_rdata, .keepalive_on, .multi_notice_on, .path_ident, .ownership, .link_defaults_restore);

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (acc_req) take_cyc = cyc;
    end
    always @(negedge clk_sys) if (link_defaults_restore === 1'b1) restore_cyc.push_back(cyc);
    initial begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
        logic ak;
        u_host_cmd_model.access(wr, a, d, rd, e, ak);
        check_val("ack", 64'h1, {63'h0, ak});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        foreach (rows[i]) begin
            do_acc(rows[i].wr, rows[i].addr, rows[i].wdata);
            check_val($sformatf("rdata %h", rows[i].addr), rows[i].exp, rd & rows[i].mask);
            check_val($sformatf("err %h", rows[i].addr), rows[i].err, e);
        end
        check_val("multi", 64'h1, multi_notice_on);
        check_val("chan", 64'h5, path_ident);
        // Captures six cycles apart; a write with bit 0 clear keeps the held time
        u_host_cmd_model.read_time(t1);
        u_host_cmd_model.read_time(t2);
        check_val("time_step", 64'h0000000000000258, t2 - t1);
        do_acc(1'b1, 16'h01F8, 32'hFFFFFFFE);
        do_acc(1'b0, 16'h01F0, 32'h0);
        check_val("time_hold", t2[31:0], rd);
        // Keepalive of 2 ms at 10 cycles per ms, held off by traffic then left to expire twice
        do_acc(1'b1, 16'h01E0, 32'h1);
        repeat (15) do_acc(1'b0, 16'h01EC, 32'h0);
        check_val("early_expiry", 64'h0, restore_cyc.size());
        repeat (45) @(negedge clk_sys);
        check_val("expiries", 64'h2, restore_cyc.size());
        // Timer expiry plus the registered restore stage: one edge beyond the timeout
        check_val("first_expiry", 64'h15, restore_cyc[0] - take_cyc);
        check_val("period", 64'h14, restore_cyc[1] - restore_cyc[0]);
        check_val("own_cleared", 64'h0, ownership);
        check_val("still_on", 64'h1, keepalive_on);
        do_acc(1'b1, 16'h01E0, 32'h0);
        n = restore_cyc.size();
        repeat (40) @(negedge clk_sys);
        check_val("disabled", n, restore_cyc.size());
        // Reset in mid-run
        arst_n = 1'b0;
        @(negedge clk_sys);
        check_val("chan_rst", 64'h0, path_ident);
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        do_acc(1'b0, 16'h01E8, 32'h0);
        check_val("timeout_rst", 64'h0BB8, rd);
        wrap_up();
    end
endmodule
